// ==== rtl/rsp_pkg.sv ====
// constants and types shared by the two-wire target port
package rsp_pkg;
  localparam int          ADDR_W        = 8;
  localparam int          DATA_W        = 8;
  localparam logic [6:0]  DEV_ID        = 7'h2a;  // arbitrary identifier value
  localparam logic [7:0]  USER_FIRST    = 8'h12;
  localparam logic [7:0]  USER_LAST     = 8'h19;
  localparam logic [7:0]  PTR_WRAP      = 8'h19;
  localparam logic [7:0]  PTR_RESET     = 8'h00;
  localparam int          USER_BYTES    = 8;
  localparam logic [3:0]  BIT_LAST      = 4'h7;
  localparam logic [7:0]  FILL_BYTE     = 8'h00;
  localparam int          SYNC_STAGES   = 2;

  typedef enum logic [5:0] {
    RSP_IDLE = 6'b000001,
    RSP_RECV = 6'b000010,
    RSP_ACK  = 6'b000100,
    RSP_SEND = 6'b001000,
    RSP_MACK = 6'b010000,
    RSP_WAIT = 6'b100000
  } rsp_state_type;

  typedef enum logic [1:0] {
    RSP_PH_ID   = 2'h0,
    RSP_PH_ADDR = 2'h1,
    RSP_PH_DATA = 2'h2
  } rsp_phase_type;
endpackage : rsp_pkg

// ==== rtl/rsp_line_if.sv ====
// sampled bus lines and decoded bus events shared with the front end
interface rsp_line_if;
  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  modport front (output scl, sda, scl_rise, scl_fall, start_ev, stop_ev);
  modport core  (input  scl, sda, scl_rise, scl_fall, start_ev, stop_ev);
endinterface : rsp_line_if

// ==== rtl/rsp_line_front.sv ====
// two-stage synchronisers and edge/condition detection for the bus lines
module rsp_line_front (
  input  wire logic  core_clk_i,
  input  wire logic  rst_n_i,
  input  wire logic  clk_en_i,
  input  wire logic  scl_i,
  input  wire logic  sda_i,
  rsp_line_if.front  line
);
  typedef struct packed {
    logic [1:0] scl_meta;
    logic [1:0] sda_meta;
    logic       scl_q;
    logic       sda_q;
  } rsp_front_type;

  rsp_front_type r;
  rsp_front_type next_r;

  always_comb begin
    next_r          = r;
    next_r.scl_meta = {r.scl_meta[0], scl_i};
    next_r.sda_meta = {r.sda_meta[0], sda_i};
    next_r.scl_q    = r.scl_meta[1];
    next_r.sda_q    = r.sda_meta[1];
  end

  // idle bus reads high; reset values keep spurious conditions away
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      r <= '{scl_meta: 2'h3, sda_meta: 2'h3, scl_q: 1'b1, sda_q: 1'b1};
    end else if (clk_en_i) begin
      r <= next_r;
    end
  end

  assign line.scl      = r.scl_meta[1];
  assign line.sda      = r.sda_meta[1];
  assign line.scl_rise = r.scl_meta[1] & ~r.scl_q;
  assign line.scl_fall = ~r.scl_meta[1] & r.scl_q;
  assign line.start_ev = r.scl_meta[1] & r.scl_q & r.sda_q & ~r.sda_meta[1];
  assign line.stop_ev  = r.scl_meta[1] & r.scl_q & ~r.sda_q & r.sda_meta[1];
endmodule : rsp_line_front

// ==== rtl/rsp_target_port.sv ====
// two-wire target port with pointer, user memory and register-array access
// Operation
// - eight user bytes at 12h..19h, readable and writable over the bus
// - port is target only; never drives clock nor starts transfers
// - bytes shift most significant bit first both ways
// - data line changes only while clock is low
// - data line released at power-up
// - wait for start; ignore bus until then and during reset
// - stop ends transaction and returns port to standby
// - sender releases after eight bits; receiver pulls low on ninth
// - acknowledge matching identifier, word address, and the first written data byte only
// - last bit of first byte: one reads, zero writes
// - compare upper seven bits after the full byte, ack only on match
// - single word address byte; pointer cleared to zero at reset
// - write: start, id, address, data, stop, all acknowledged
// - keep sending bytes while controller acknowledges each
// - read pointer increments per byte and wraps 19h to 00h
module rsp_target_port #(
  parameter logic [6:0] DEVICE_ID = rsp_pkg::DEV_ID  // arbitrary identifier value
) (
  input  wire logic                       core_clk_i,
  input  wire logic                       rst_n_i,
  input  wire logic                       clk_en_i,
  input  wire logic                       scl_i,
  input  wire logic                       sda_i,
  output logic                            sda_o,
  output logic                            sda_oe_o,
  input  wire logic [rsp_pkg::DATA_W-1:0] ccr_rdata_i,
  output logic      [rsp_pkg::ADDR_W-1:0] ccr_addr_o,
  output logic      [rsp_pkg::DATA_W-1:0] ccr_wdata_o,
  output logic                            ccr_we_o,
  output logic                            busy_o
);
  import rsp_pkg::*;

  typedef struct packed {
    rsp_state_type               state;
    rsp_phase_type               phase;
    logic [3:0]                  bit_cnt;
    logic [DATA_W-1:0]           shreg;
    logic [ADDR_W-1:0]           ptr;
    logic                        rd_mode;
    logic                        ack_drive;
    logic                        sda_oe;
    logic [ADDR_W-1:0]           ccr_addr;
    logic [DATA_W-1:0]           ccr_wdata;
    logic                        ccr_we;
    logic                        busy;
    logic [1:0]                  settle;
  } rsp_core_type;

  rsp_core_type      r;
  rsp_core_type      next_r;
  logic [DATA_W-1:0] user_mem [USER_BYTES];
  logic              mem_we;
  logic [2:0]        mem_idx;
  logic [DATA_W-1:0] mem_wdata;
  logic [DATA_W-1:0] rd_byte;
  logic              in_user;

  // events are ignored until the synchronisers have flushed their reset fill
  localparam logic [1:0] SETTLE_DONE = 2'(SYNC_STAGES + 1);

  rsp_line_if line ();

  rsp_line_front u_front (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .clk_en_i   (clk_en_i),
    .scl_i      (scl_i),
    .sda_i      (sda_i),
    .line       (line)
  );

  function automatic logic [ADDR_W-1:0] ptr_next(input logic [ADDR_W-1:0] p);
    logic [ADDR_W-1:0] n;
    n = (p >= PTR_WRAP) ? PTR_RESET : ADDR_W'(p + 8'h01);
    return n;
  endfunction : ptr_next

  assign in_user = (r.ptr >= USER_FIRST) && (r.ptr <= USER_LAST);
  assign mem_idx = 3'(r.ptr - USER_FIRST);
  assign rd_byte = in_user ? user_mem[mem_idx] : ccr_rdata_i;

  always_comb begin
    next_r        = r;
    next_r.ccr_we = 1'b0;
    mem_we        = 1'b0;
    mem_wdata     = r.shreg;
    if (r.settle != SETTLE_DONE) begin
      // synchronisers still carry the reset ones, so an edge here is not real
      next_r.settle = 2'(r.settle + 2'h1);
    end else if (line.start_ev) begin
      // repeated start lands here too, keeping the pointer for the read
      next_r.state   = RSP_RECV;
      next_r.phase   = RSP_PH_ID;
      next_r.bit_cnt = 4'h0;
      next_r.sda_oe  = 1'b0;
      next_r.busy    = 1'b1;
    end else if (line.stop_ev) begin
      next_r.state  = RSP_IDLE;
      next_r.sda_oe = 1'b0;
      next_r.busy   = 1'b0;
      next_r.ack_drive = 1'b0;
      next_r.bit_cnt   = 4'h0;
    end else begin
      case (r.state)
        RSP_IDLE: begin
          next_r.sda_oe = 1'b0;
        end
        RSP_RECV: begin
          if (line.scl_rise) begin
            next_r.shreg   = {r.shreg[DATA_W-2:0], line.sda};
            next_r.bit_cnt = 4'(r.bit_cnt + 4'h1);
          end else if (line.scl_fall && r.bit_cnt == 4'(BIT_LAST + 4'h1)) begin
            next_r.bit_cnt   = 4'h0;
            next_r.ack_drive = 1'b1;
            next_r.state     = RSP_ACK;
            case (r.phase)
              RSP_PH_ID: begin
                if (r.shreg[7:1] == DEVICE_ID) begin
                  next_r.rd_mode = r.shreg[0];
                end else begin
                  next_r.ack_drive = 1'b0;
                  next_r.state     = RSP_WAIT;
                end
              end
              RSP_PH_ADDR: begin
                next_r.ptr = r.shreg;
              end
              default: begin
                if (in_user) begin
                  mem_we = 1'b1;
                end else begin
                  next_r.ccr_we = 1'b1;
                end
                next_r.ccr_addr  = r.ptr;
                next_r.ccr_wdata = r.shreg;
              end
            endcase
            // drive on the falling edge so data changes only with clock low
            next_r.sda_oe = next_r.ack_drive;
          end
        end
        RSP_ACK: begin
          if (line.scl_fall) begin
            next_r.sda_oe    = 1'b0;
            next_r.ack_drive = 1'b0;
            if (r.phase == RSP_PH_ID && r.rd_mode) begin
              next_r.state  = RSP_SEND;
              next_r.shreg  = rd_byte;
              next_r.sda_oe = ~rd_byte[DATA_W-1];
            end else if (r.phase == RSP_PH_ID) begin
              next_r.phase = RSP_PH_ADDR;
              next_r.state = RSP_RECV;
            end else if (r.phase == RSP_PH_ADDR) begin
              next_r.phase = RSP_PH_DATA;
              next_r.state = RSP_RECV;
            end else begin
              // single-byte write: further bytes are ignored until stop
              next_r.state = RSP_WAIT;
            end
          end
        end
        RSP_SEND: begin
          if (line.scl_fall) begin
            if (r.bit_cnt == BIT_LAST) begin
              next_r.bit_cnt = 4'h0;
              next_r.sda_oe  = 1'b0;
              next_r.ptr     = ptr_next(r.ptr);
              next_r.state   = RSP_MACK;
            end else begin
              next_r.bit_cnt = 4'(r.bit_cnt + 4'h1);
              next_r.shreg   = {r.shreg[DATA_W-2:0], 1'b0};
              next_r.sda_oe  = ~r.shreg[DATA_W-2];
            end
          end
        end
        RSP_MACK: begin
          if (line.scl_rise) begin
            next_r.rd_mode = ~line.sda; // controller ack keeps streaming
          end else if (line.scl_fall) begin
            if (r.rd_mode) begin
              next_r.state  = RSP_SEND;
              next_r.shreg  = rd_byte;
              next_r.sda_oe = ~rd_byte[DATA_W-1];
            end else begin
              next_r.state = RSP_WAIT;
            end
          end
        end
        RSP_WAIT: begin
          next_r.sda_oe = 1'b0;
        end
        default: begin
          next_r.state = RSP_IDLE;
        end
      endcase
    end
    // array read data is taken at the pointer, so the address follows it
    next_r.ccr_addr = next_r.ptr;
  end

  // pointer zeroed at reset; only the data line is ever driven
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      r.state     <= RSP_IDLE;
      r.phase     <= RSP_PH_ID;
      r.bit_cnt   <= 4'h0;
      r.shreg     <= FILL_BYTE;
      r.ptr       <= PTR_RESET;
      r.rd_mode   <= 1'b0;
      r.ack_drive <= 1'b0;
      r.sda_oe    <= 1'b0;
      r.ccr_addr  <= PTR_RESET;
      r.ccr_wdata <= FILL_BYTE;
      r.ccr_we    <= 1'b0;
      r.busy      <= 1'b0;
      r.settle    <= 2'h0;
    end else if (clk_en_i) begin
      r <= next_r;
    end
  end

  // backup-retained storage is not cleared by reset
  always_ff @(posedge core_clk_i) begin
    if (clk_en_i && mem_we) begin
      user_mem[mem_idx] <= mem_wdata;
    end
  end

  assign sda_o       = 1'b0;
  assign sda_oe_o    = r.sda_oe;
  assign ccr_addr_o  = r.ccr_addr;
  assign ccr_wdata_o = r.ccr_wdata;
  assign ccr_we_o    = r.ccr_we;
  assign busy_o      = r.busy;
endmodule : rsp_target_port

// ==== verification/rsp_target_chk.sv ====
// pin-level assertions for the two-wire target port
module rsp_target_chk
  import rsp_pkg::*;
(
  input wire logic                       core_clk_i,
  input wire logic                       rst_n_i,
  input wire logic                       scl_i,
  input wire logic                       sda_i,
  input wire logic                       sda_o,
  input wire logic                       sda_oe_o,
  input wire logic [rsp_pkg::ADDR_W-1:0] ccr_addr_o,
  input wire logic                       ccr_we_o,
  input wire logic                       busy_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  // scl high on both samples, so a release racing the scl rise is not taken as an event
  sequence s_start;
    $past(scl_i) && scl_i && $fell(sda_i);
  endsequence
  sequence s_stop;
    $past(scl_i) && scl_i && $rose(sda_i);
  endsequence
  property p_open_drain;
    sda_o == 1'b0;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("data pin driven high");
  property p_rst_quiet;
    disable iff (1'b0) !rst_n_i |=> !sda_oe_o && !busy_o && !ccr_we_o;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("outputs active after reset");
  property p_hold_high;
    $past(scl_i, 3) && scl_i |-> $stable(sda_oe_o);
  endproperty
  a_hold_high: assert property (p_hold_high) else $error("data changed in clock high");
  property p_idle_release;
    !busy_o |-> !sda_oe_o;
  endproperty
  a_idle_release: assert property (p_idle_release) else $error("drive outside transfer");
  property p_start_busy;
    s_start |-> ##[1:8] busy_o;
  endproperty
  a_start_busy: assert property (p_start_busy) else $error("start not taken");
  property p_stop_idle;
    s_stop |-> ##[1:8] !busy_o;
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("stop did not end transfer");
  property p_we_pulse;
    ccr_we_o |=> !ccr_we_o;
  endproperty
  a_we_pulse: assert property (p_we_pulse) else $error("write strobe too long");
  property p_we_acked;
    ccr_we_o |-> sda_oe_o && busy_o;
  endproperty
  a_we_acked: assert property (p_we_acked) else $error("write without acknowledge");
  property p_we_range;
    ccr_we_o |-> (ccr_addr_o < USER_FIRST) || (ccr_addr_o > USER_LAST);
  endproperty
  a_we_range: assert property (p_we_range) else $error("user byte sent to array");
endmodule : rsp_target_chk

bind rsp_target_port rsp_target_chk u_chk (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
  .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
  .ccr_addr_o(ccr_addr_o), .ccr_we_o(ccr_we_o), .busy_o(busy_o));

// ==== verification/rsp_bus_ctl.sv ====
// bus controller model: makes the clock, start, stop and bytes
module rsp_bus_ctl (
  input  wire logic core_clk_i,
  input  wire logic sda_line_i,
  output logic      scl_o,
  output logic      sda_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // clock parked high between frames
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask : tick
  // one 320 ns bus clock; line read mid-high, well after the target settles
  task automatic bit_cyc(input logic b, output logic q);
    tick(2);
    sda_o <= b;
    tick(2);
    scl_o <= 1'b1;
    tick(2);
    q = sda_line_i;
    tick(2);
    scl_o <= 1'b0;
  endtask : bit_cyc
  task automatic gen_start();
    tick(2);
    sda_o <= 1'b1;
    tick(2);
    scl_o <= 1'b1;
    tick(4);
    sda_o <= 1'b0;
    tick(4);
    scl_o <= 1'b0;
  endtask : gen_start
  task automatic gen_stop();
    tick(2);
    sda_o <= 1'b0;
    tick(2);
    scl_o <= 1'b1;
    tick(4);
    sda_o <= 1'b1;
    tick(8);
  endtask : gen_stop
  task automatic put_byte(input logic [7:0] v, output logic ak);
    logic q;
    for (int i = 7; i >= 0; i--) bit_cyc(v[i], q);
    bit_cyc(1'b1, q);
    ak = ~q;
  endtask : put_byte
  task automatic get_byte(input logic last, output logic [7:0] v);
    logic q;
    for (int i = 7; i >= 0; i--) bit_cyc(1'b1, v[i]);
    bit_cyc(last, q);
  endtask : get_byte
endmodule : rsp_bus_ctl

// ==== verification/rsp_target_port_test.sv ====
// self-checking bench: register writes and reads over the two-wire port
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin error_cnt++; \
  $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module rsp_target_port_test;
  timeunit 1ns;
  timeprecision 1ps;
  import rsp_pkg::*;
  localparam logic [7:0] CCR_VAL = 8'h5c;
  logic       core_clk_i = 1'b0;
  logic       rst_n_i    = 1'b0;
  logic       scl, sda_c, sda_oe, busy, we, ak;
  logic [7:0] addr, wdata, we_addr, we_data, d;
  int         error_cnt = 0, checks_done = 0, we_cnt = 0, cyc = 0;
  wire        sda_line = sda_c & ~sda_oe;  // pull-up on the shared line
  always #20 core_clk_i = ~core_clk_i;
  rsp_bus_ctl ctl (.core_clk_i(core_clk_i), .sda_line_i(sda_line), .scl_o(scl), .sda_o(sda_c));
  // array model: read data is a known function of the presented address
  wire  [7:0] ccr_rdata = CCR_VAL ^ addr;
  rsp_target_port uut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .clk_en_i(1'b1),
    .scl_i(scl), .sda_i(sda_line), .sda_o(), .sda_oe_o(sda_oe), .ccr_rdata_i(ccr_rdata),
    .ccr_addr_o(addr), .ccr_wdata_o(wdata), .ccr_we_o(we), .busy_o(busy));
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (we === 1'b1) begin
      we_cnt  <= we_cnt + 1;
      we_addr <= addr;
      we_data <= wdata;
    end
    if (cyc == 20000) begin
      error_cnt++;
      test_done();
    end
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : test_done
  task automatic hdr(input logic [6:0] id, input logic rd, input logic exp);
    ctl.gen_start();
    ctl.put_byte({id, rd}, ak);
    `CHK("id_ack", exp, ak)
  endtask : hdr
  // second data byte must be refused and not stored
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    hdr(DEV_ID, 1'b0, 1'b1);
    ctl.put_byte(a, ak);
    `CHK("addr_ack", 1'b1, ak)
    ctl.put_byte(v, ak);
    `CHK("data_ack", 1'b1, ak)
    ctl.put_byte(~v, ak);
    `CHK("extra_ack", 1'b0, ak)
    ctl.gen_stop();
  endtask : wr
  initial begin
    repeat (5) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    repeat (6) @(posedge core_clk_i);
    hdr(DEV_ID, 1'b1, 1'b1);
    ctl.get_byte(1'b1, d);
    `CHK("cur_read", CCR_VAL ^ PTR_RESET, d)
    ctl.gen_stop();
    `CHK("busy_stop", 1'b0, busy)
    $display("test current-address read done");
    for (int i = 0; i < USER_BYTES; i++) wr(USER_FIRST + 8'(i), 8'ha0 + 8'(i));
    wr(8'h05, 8'h3c);
    `CHK("we_cnt", 1, we_cnt)
    `CHK("we_addr", 8'h05, we_addr)
    `CHK("we_data", 8'h3c, we_data)
    $display("test writes done");
    hdr(DEV_ID, 1'b0, 1'b1);
    ctl.put_byte(USER_FIRST, ak);
    `CHK("raddr_ack", 1'b1, ak)
    hdr(DEV_ID, 1'b1, 1'b1);
    // bytes 8 and 9 come from array locations 00h and 01h after the wrap
    for (int i = 0; i < 10; i++) begin
      ctl.get_byte(i == 9, d);
      `CHK("seq_read", (i < 8) ? 8'ha0 + 8'(i) : CCR_VAL ^ 8'(i - 8), d)
    end
    ctl.gen_stop();
    $display("test sequential read done");
    hdr(DEV_ID ^ 7'h40, 1'b0, 1'b0);
    ctl.put_byte(8'h07, ak);
    `CHK("ignored_ack", 1'b0, ak)
    ctl.gen_stop();
    `CHK("we_cnt_foreign", 1, we_cnt)
    $display("test foreign identifier done");
    test_done();
  end
endmodule : rsp_target_port_test
